// [rtl/itxfc_pkg.sv]
// itxfc_pkg: register map, field positions and reset values of the
// transmit fifo control block.
// assumes a 32-bit Avalon-MM slave port with byte addresses.
package itxfc_pkg;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] ITXFC_OFS_TXC_PRI = 8'h24;
    localparam logic [7:0] ITXFC_OFS_TXC_SEC = 8'h28;
    localparam logic [7:0] ITXFC_OFS_TX_DATA = 8'h40;
    localparam logic [7:0] ITXFC_OFS_INT_STS = 8'h44;
    localparam logic [7:0] ITXFC_OFS_INT_MSK = 8'h48;

    // ==========================================================
    // tx_control_primary fields
    localparam int ITXFC_PRI_PRELOAD = 0;

    // ==========================================================
    // tx_control_secondary fields
    localparam int ITXFC_SEC_TXRDY = 0;
    localparam int ITXFC_SEC_GC_DIS = 2;
    localparam int ITXFC_SEC_SLA_DIS = 4;
    localparam int ITXFC_SEC_NACK_DIS = 5;
    localparam int ITXFC_SEC_CNT_LO = 8;
    localparam int ITXFC_SEC_CNT_HI = 11;
    // writable storage bits of the secondary register (count excluded)
    localparam logic [31:0] ITXFC_SEC_WR_MASK = 32'hFFFF_F0FF;
    localparam logic [31:0] ITXFC_SEC_RESET = 32'h0000_0001;
    localparam logic [31:0] ITXFC_PRI_RESET = 32'h0000_0000;

    // ==========================================================
    // interrupt status / mask fields
    localparam int ITXFC_INT_LOCK = 0;
    localparam int ITXFC_INT_FLUSH = 1;
    localparam int ITXFC_INT_W = 2;
    localparam logic [ITXFC_INT_W-1:0] ITXFC_INT_RESET = 2'h0;

    // ==========================================================
    // fifo defaults
    localparam int ITXFC_FIFO_DEPTH = 8;
    localparam int ITXFC_FIFO_WIDTH = 8;

    // bus slave handshake phase
    typedef enum logic [0:0] {
        ITXFC_BUS_IDLE = 1'b0,
        ITXFC_BUS_ACK  = 1'b1
    } itxfc_bus_t;

endpackage

// [rtl/itxfc_fifo_if.sv]
// itxfc_fifo_if: connection between the control logic and the fifo
// storage. all signals are synchronous to one clock.
`timescale 1ns/1ps
interface itxfc_fifo_if #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
);
    logic push;
    logic [WIDTH-1:0] push_data;
    logic pop;
    logic flush;
    logic [WIDTH-1:0] pop_data;
    logic [$clog2(DEPTH):0] count;
    logic full;
    logic empty;

    modport ctrl (output push, push_data, pop, flush,
                  input pop_data, count, full, empty);
    modport mem (input push, push_data, pop, flush,
                 output pop_data, count, full, empty);
endinterface

// [rtl/itxfc_fifo.sv]
// itxfc_fifo: transmit byte storage with registered read data.
// assumes the controller never pushes when full or pops when empty;
// such requests are dropped. flush wins over push and pop.
`timescale 1ns/1ps
module itxfc_fifo
    import itxfc_pkg::*;
#(
    parameter int WIDTH = ITXFC_FIFO_WIDTH,
    parameter int DEPTH = ITXFC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // fifo port
    itxfc_fifo_if.mem f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [WIDTH-1:0] rdata_r;
    wire do_push = f.push && !f.full && !f.flush;
    wire do_pop = f.pop && !f.empty && !f.flush;

    assign f.count = count_r;
    assign f.full = (count_r == (AW+1)'(DEPTH));
    assign f.empty = (count_r == '0);
    assign f.pop_data = rdata_r;

    // ==========================================================
    // storage, no reset needed on the array
    always_ff @(posedge i_core_clk) begin
        if (do_push) begin
            mem_r[wr_ptr_r] <= f.push_data;
        end
    end

    // ==========================================================
    // pointers and count; flush empties in one cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n || f.flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            rdata_r <= '0;
        end else if (do_pop) begin
            rdata_r <= mem_r[rd_ptr_r];
        end
    end
endmodule // itxfc_fifo

// [rtl/itxfc_top.sv]
// itxfc_top: transmit fifo control of a two-wire serial slave.
// assumes the serial engine gives one-cycle event pulses synchronous
// to i_core_clk and pops a byte per pulse of i_tx_pop.
// Summary of operation
// - preload off: match locks, sets lock flag, flushes unless its disable bit is set
// - preload on: match neither locks nor sets flag
// - secondary bits 11:8 report fifo byte count
// - bit 5 clear: nack at end flushes fifo
// - bit 4 clear: slave address match flushes fifo
// - bit 2 clear: general call match flushes fifo
// - disable bits ignored in master mode
// - preload: ready cleared, nack address until set
`timescale 1ns/1ps
module itxfc_top
    import itxfc_pkg::*;
#(
    parameter int FIFO_DEPTH = ITXFC_FIFO_DEPTH,
    parameter int FIFO_WIDTH = ITXFC_FIFO_WIDTH
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // avalon-mm slave
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // serial engine events
    input wire logic i_master_mode,
    input wire logic i_sla_match,
    input wire logic i_gc_match,
    input wire logic i_nack_end,
    input wire logic i_tx_pop,
    // serial engine data and status
    output logic [FIFO_WIDTH-1:0] o_tx_data,
    output logic o_tx_empty,
    output logic o_addr_ack,
    // interrupt
    output logic o_irq
);
    // ==========================================================
    // helpers
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction

    // ==========================================================
    // fifo instance
    itxfc_fifo_if #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) fif ();

    itxfc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .f(fif.mem)
    );

    // ==========================================================
    // bus slave: one wait cycle, then answer
    itxfc_bus_t bus_r;
    logic [31:0] rdata_r;
    logic [31:0] pri_r;
    logic [31:0] sec_r;
    logic [ITXFC_INT_W-1:0] sts_r;
    logic [ITXFC_INT_W-1:0] msk_r;

    wire req = i_avs_read || i_avs_write;
    wire acc = req && (bus_r == ITXFC_BUS_ACK);
    wire wr_en = i_avs_write && acc;
    wire [31:0] wmask = be_mask(i_avs_byteenable);
    wire wr_pri = wr_en && (i_avs_address == ITXFC_OFS_TXC_PRI);
    wire wr_sec = wr_en && (i_avs_address == ITXFC_OFS_TXC_SEC);
    wire wr_dat = wr_en && (i_avs_address == ITXFC_OFS_TX_DATA) && i_avs_byteenable[0];
    wire wr_sts = wr_en && (i_avs_address == ITXFC_OFS_INT_STS);
    wire wr_msk = wr_en && (i_avs_address == ITXFC_OFS_INT_MSK);

    assign o_avs_waitrequest = req && (bus_r == ITXFC_BUS_IDLE);
    assign o_avs_readdata = rdata_r;

    // ==========================================================
    // event decode
    wire preload = pri_r[ITXFC_PRI_PRELOAD];
    wire slave = !i_master_mode;
    wire match = slave && (i_sla_match || i_gc_match);
    wire lock = sts_r[ITXFC_INT_LOCK];
    // disable bits are only looked at in slave mode
    wire fl_sla = slave && i_sla_match && !sec_r[ITXFC_SEC_SLA_DIS];
    wire fl_gc = slave && i_gc_match && !sec_r[ITXFC_SEC_GC_DIS];
    wire fl_nack = slave && i_nack_end && !sec_r[ITXFC_SEC_NACK_DIS];
    // preload mode keeps the preloaded bytes on a match
    wire auto_flush = ((fl_sla || fl_gc) && !preload) || fl_nack;
    wire lock_set = match && !preload;
    wire txrdy = preload ? sec_r[ITXFC_SEC_TXRDY] : 1'b1;
    // preload was clear, so only the written lane decides a rise
    wire pre_rise = wr_pri && !preload && wmask[ITXFC_PRI_PRELOAD] &&
                    i_avs_writedata[ITXFC_PRI_PRELOAD];

    // ==========================================================
    // fifo side
    assign fif.flush = auto_flush;
    // writes are dropped while the fifo is locked
    assign fif.push = wr_dat && !lock;
    assign fif.push_data = i_avs_writedata[FIFO_WIDTH-1:0];
    assign fif.pop = i_tx_pop;
    assign o_tx_data = fif.pop_data;
    assign o_tx_empty = fif.empty;
    assign o_addr_ack = slave && txrdy;
    assign o_irq = |(sts_r & msk_r);

    // ==========================================================
    // read mux
    logic [31:0] sec_view;
    logic [31:0] rd_mux;
    always_comb begin
        sec_view = sec_r;
        sec_view[ITXFC_SEC_CNT_HI:ITXFC_SEC_CNT_LO] = 4'(fif.count);
        sec_view[ITXFC_SEC_TXRDY] = txrdy;
        unique case (i_avs_address)
            ITXFC_OFS_TXC_PRI: rd_mux = pri_r;
            ITXFC_OFS_TXC_SEC: rd_mux = sec_view;
            ITXFC_OFS_INT_STS: rd_mux = 32'(sts_r);
            ITXFC_OFS_INT_MSK: rd_mux = 32'(msk_r);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            bus_r <= ITXFC_BUS_IDLE;
            rdata_r <= 32'h0000_0000;
        end else begin
            bus_r <= (req && bus_r == ITXFC_BUS_IDLE) ? ITXFC_BUS_ACK : ITXFC_BUS_IDLE;
            if (i_avs_read && bus_r == ITXFC_BUS_IDLE) begin
                rdata_r <= rd_mux;
            end
        end
    end

    // ==========================================================
    // control registers; reserved bits of primary and secondary are plain storage
    logic [31:0] sec_nxt;
    wire [31:0] msk_wd = merge(32'(msk_r), i_avs_writedata, wmask);
    always_comb begin
        sec_nxt = sec_r;
        if (wr_sec) begin
            sec_nxt = merge(sec_r, i_avs_writedata, wmask & ITXFC_SEC_WR_MASK);
        end
        if (pre_rise) begin
            sec_nxt[ITXFC_SEC_TXRDY] = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pri_r <= ITXFC_PRI_RESET;
            sec_r <= ITXFC_SEC_RESET;
            msk_r <= ITXFC_INT_RESET;
        end else begin
            if (wr_pri) begin
                pri_r <= merge(pri_r, i_avs_writedata, wmask);
            end
            sec_r <= sec_nxt;
            if (wr_msk) begin
                msk_r <= msk_wd[ITXFC_INT_W-1:0];
            end
        end
    end

    // ==========================================================
    // sticky status, write one to clear; a new event wins
    logic [ITXFC_INT_W-1:0] sts_set;
    logic [ITXFC_INT_W-1:0] sts_clr;
    assign sts_set = {auto_flush, lock_set};
    assign sts_clr = wr_sts ? (i_avs_writedata[ITXFC_INT_W-1:0] &
                               wmask[ITXFC_INT_W-1:0]) : '0;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            sts_r <= ITXFC_INT_RESET;
        end else begin
            sts_r <= (sts_r & ~sts_clr) | sts_set;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_match_normal;
        match && !preload;
    endsequence

    sequence s_locked_empty;
        lock ##0 (fif.count == '0);
    endsequence

    property p_match_lock;
        s_match_normal |=> lock;
    endproperty
    a_match_lock: assert property (p_match_lock)
        else $error("match without preload did not lock");

    // a match whose flush is not disabled must both lock and empty
    sequence s_flush_armed;
        slave && !preload && ((i_sla_match && !sec_r[ITXFC_SEC_SLA_DIS]) ||
                              (i_gc_match && !sec_r[ITXFC_SEC_GC_DIS]));
    endsequence

    property p_match_flush;
        s_flush_armed |=> s_locked_empty;
    endproperty
    a_match_flush: assert property (p_match_flush)
        else $error("enabled match flush did not empty the locked fifo");

    property p_no_lock_preload;
        $rose(lock) |-> $past(!preload && match);
    endproperty
    a_no_lock_preload: assert property (p_no_lock_preload)
        else $error("lock flag set without a normal-mode match");

    property p_count_read;
        (i_avs_read && (i_avs_address == ITXFC_OFS_TXC_SEC) && bus_r == ITXFC_BUS_IDLE)
            |=> (o_avs_readdata[11:8] == $past(4'(fif.count))) && !o_avs_waitrequest;
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("byte count field differs from fifo count");

    property p_nack_flush;
        (slave && i_nack_end && !sec_r[ITXFC_SEC_NACK_DIS]) |=> o_tx_empty;
    endproperty
    a_nack_flush: assert property (p_nack_flush)
        else $error("nack did not flush the fifo");

    property p_sla_dis;
        (i_sla_match && sec_r[ITXFC_SEC_SLA_DIS] && !i_gc_match && !i_nack_end)
            |-> !auto_flush;
    endproperty
    a_sla_dis: assert property (p_sla_dis)
        else $error("flush on address match while disabled");

    property p_gc_dis;
        (i_gc_match && sec_r[ITXFC_SEC_GC_DIS] && !i_sla_match && !i_nack_end)
            |-> !auto_flush;
    endproperty
    a_gc_dis: assert property (p_gc_dis)
        else $error("flush on general call while disabled");

    property p_master_ignore;
        i_master_mode |-> !auto_flush && !lock_set;
    endproperty
    a_master_ignore: assert property (p_master_ignore)
        else $error("auto flush acted in master mode");

    property p_preload_nack;
        (preload && !sec_r[ITXFC_SEC_TXRDY]) |-> !o_addr_ack;
    endproperty
    a_preload_nack: assert property (p_preload_nack)
        else $error("address acknowledged before ready");

    property p_flush_all;
        auto_flush |=> (fif.count == '0) ##1 (fif.count <= 1);
    endproperty
    a_flush_all: assert property (p_flush_all)
        else $error("auto flush left bytes behind");

    property p_lock_drop;
        (lock && wr_dat && !i_tx_pop && !auto_flush) |=> (fif.count == $past(fif.count));
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("data write landed while the fifo was locked");

    // lock is sticky until software writes a one to it
    wire lock_w1c = wr_sts && i_avs_writedata[ITXFC_INT_LOCK] && i_avs_byteenable[0];

    property p_lock_hold;
        (lock && !lock_w1c) |=> lock;
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lock flag dropped without a software clear");

    property p_lock_clear;
        (lock && lock_w1c && !match) |=> !lock;
    endproperty
    a_lock_clear: assert property (p_lock_clear)
        else $error("lock flag survived a write-one clear");

    property p_ready_forced;
        !preload |-> (o_addr_ack == !i_master_mode);
    endproperty
    a_ready_forced: assert property (p_ready_forced)
        else $error("address ack not forced outside preload");

    property p_ready_clear;
        $rose(preload) |-> !sec_r[ITXFC_SEC_TXRDY];
    endproperty
    a_ready_clear: assert property (p_ready_clear)
        else $error("ready bit not cleared on entering preload");

    property p_ready_hold;
        (preload && !sec_r[ITXFC_SEC_TXRDY] && !wr_sec) |=> !sec_r[ITXFC_SEC_TXRDY];
    endproperty
    a_ready_hold: assert property (p_ready_hold)
        else $error("ready bit set without a software write");

    sequence s_bus_first;
        req && (bus_r == ITXFC_BUS_IDLE);
    endsequence

    property p_one_wait;
        s_bus_first |-> o_avs_waitrequest ##1 (!req || !o_avs_waitrequest);
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("bus answer not after exactly one wait state");

    property p_push_count;
        (wr_dat && !lock && !fif.full && !auto_flush && !i_tx_pop)
            |=> (fif.count == $past(fif.count) + 1'b1);
    endproperty
    a_push_count: assert property (p_push_count)
        else $error("accepted data byte not counted");

    property p_count_max;
        fif.count <= FIFO_DEPTH;
    endproperty
    a_count_max: assert property (p_count_max)
        else $error("byte count above fifo depth");
endmodule // itxfc_top

// [testbench/itxfc_engine_model.sv]
// itxfc_engine_model: serial engine and far bus master driving events.
// assumes calls start just after a rising edge of i_core_clk.
`timescale 1ns/1ps
module itxfc_engine_model (
    // clock
    input wire logic i_core_clk,
    // events
    output logic o_master_mode,
    output logic [3:0] o_evt
);
    // ==========
    // drivers
    initial begin
        o_master_mode = 1'b0;
        o_evt = 4'h0;
    end
    task automatic set_master(input logic m);
        o_master_mode <= m;
        @(posedge i_core_clk);
    endtask
    // one-cycle pulse of any event pattern, then a quiet cycle
    task automatic pulse(input logic [3:0] v);
        o_evt <= v;
        @(posedge i_core_clk);
        o_evt <= 4'h0;
        @(posedge i_core_clk);
    endtask
    // one-cycle pulse: 0 sla, 1 gc, 2 nack, 3 pop
    task automatic fire(input int k);
        pulse(4'h1 << k);
    endtask
endmodule // itxfc_engine_model

// [testbench/tb_top.sv]
// tb_top: self-checking bench of the transmit fifo control.
// assumes the engine model owns the event pins; registers via avalon.
`timescale 1ns/1ps
module tb_top;
    import itxfc_pkg::*;
    logic i_core_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
    logic [7:0] i_avs_address, o_tx_data;
    logic [3:0] i_avs_byteenable, evt, be;
    logic [31:0] i_avs_writedata, o_avs_readdata, rd, sec_store;
    logic i_master_mode, o_tx_empty, o_addr_ack, o_irq, pre;
    logic [31:0] seed = 32'hF85A723E;
    logic [7:0] q[$];
    int miscompares = 0, samples_checked = 0, n, d, k;
    int dis_pos[3] = '{4, 2, 5};
    itxfc_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_byteenable(i_avs_byteenable), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .i_master_mode(i_master_mode), .i_sla_match(evt[0]), .i_gc_match(evt[1]),
        .i_nack_end(evt[2]), .i_tx_pop(evt[3]), .o_tx_data(o_tx_data),
        .o_tx_empty(o_tx_empty), .o_addr_ack(o_addr_ack), .o_irq(o_irq));
    itxfc_engine_model eng (.i_core_clk(i_core_clk), .o_master_mode(i_master_mode),
        .o_evt(evt));
    // ==========
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // count field over storage; ready bit forced high outside preload
    function automatic logic [31:0] sec_exp(int c);
        sec_exp = (sec_store & 32'hFFFF_F0FF) | (32'(c) << 8);
        if (!pre) sec_exp[0] = 1'b1;
    endfunction
    task automatic print_verdict();
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        int i;
        i_avs_address <= a;
        i_avs_writedata <= dat;
        i_avs_byteenable <= be;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge i_core_clk);
            if (o_avs_waitrequest === 1'b0) break;
        end
        if (i == 20) begin
            miscompares++;
            print_verdict();
        end
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_core_clk);
    endtask
    task automatic chk_cnt(input int c);
        bus(1'b0, ITXFC_OFS_TXC_SEC, 32'h0);
        chk(rd, sec_exp(c));
    endtask
    task automatic fill(input int c);
        logic [7:0] b;
        repeat (c) begin
            b = 8'(rnd());
            bus(1'b1, ITXFC_OFS_TX_DATA, {24'h0, b});
            if (q.size() < 8) q.push_back(b);
        end
    endtask
    // pops everything and compares order and empty flag
    task automatic drain();
        while (q.size() > 0) begin
            eng.fire(3);
            chk(o_tx_data, q.pop_front());
        end
        chk(o_tx_empty, 1'b1);
    endtask
    // read-modify-write: reserved bits except bit 1 go back exactly as read
    task automatic set_sec(input logic [31:0] v);
        bus(1'b0, ITXFC_OFS_TXC_SEC, 32'h0);
        sec_store = (rd & 32'hFFFF_F0C8) | (v & 32'h0000_0F37);
        bus(1'b1, ITXFC_OFS_TXC_SEC, sec_store);
    endtask
    // ==========
    // clock and sequence
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    initial begin
        i_rst_n = 1'b0;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_address = 8'h0;
        i_avs_byteenable = 4'hF;
        be = 4'hF;
        i_avs_writedata = 32'h0;
        pre = 1'b0;
        sec_store = 32'h0000_0001;
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        chk({o_tx_empty, o_addr_ack, o_irq}, 3'b110);
        bus(1'b0, ITXFC_OFS_TXC_PRI, 32'h0);
        chk(rd, 32'h0);
        chk_cnt(0);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0);
        set_sec(rnd());
        chk_cnt(0);
        set_sec(32'h0000_0001);
        // lane 0 disabled: data push and mask write both refused
        be = 4'(rnd()) & 4'hE;
        bus(1'b1, ITXFC_OFS_TX_DATA, 32'hA5);
        bus(1'b1, ITXFC_OFS_INT_MSK, 32'h3);
        be = 4'hF;
        chk_cnt(0);
        bus(1'b0, ITXFC_OFS_INT_MSK, 32'h0);
        chk(rd, 32'h0);
        // full fifo refuses the ninth byte
        fill(9);
        chk_cnt(8);
        drain();
        bus(1'b1, ITXFC_OFS_INT_MSK, 32'h3);
        for (k = 0; k < 3; k++) begin
            for (d = 0; d < 2; d++) begin
                set_sec(32'h1 | (32'(d) << dis_pos[k]));
                n = 1 + rnd() % 8;
                fill(n);
                eng.fire(k);
                chk_cnt(d ? n : 0);
                if (!d) q.delete();
                bus(1'b1, ITXFC_OFS_TX_DATA, 32'h5A);
                chk_cnt(k < 2 ? (d ? n : 0) : (d ? (n < 8 ? n + 1 : 8) : 1));
                if (k == 2 && q.size() < 8) q.push_back(8'h5A);
                bus(1'b0, ITXFC_OFS_INT_STS, 32'h0);
                chk(rd, {30'h0, !d, k < 2});
                chk(o_irq, k < 2 || !d);
                bus(1'b1, ITXFC_OFS_INT_STS, 32'h3);
                chk(o_irq, 1'b0);
                drain();
            end
        end
        // masked lock does not reach the interrupt line
        bus(1'b1, ITXFC_OFS_INT_MSK, 32'h2);
        eng.fire(1);
        bus(1'b0, ITXFC_OFS_INT_STS, 32'h0);
        chk(rd, 32'h3);
        chk(o_irq, 1'b1);
        bus(1'b1, ITXFC_OFS_INT_STS, 32'h2);
        chk(o_irq, 1'b0);
        bus(1'b1, ITXFC_OFS_INT_STS, 32'h3);
        // master mode ignores every match and nack event
        eng.set_master(1'b1);
        chk(o_addr_ack, 1'b0);
        fill(3);
        for (k = 0; k < 3; k++) eng.fire(k);
        eng.pulse(4'(rnd()) & 4'h7);
        chk_cnt(3);
        bus(1'b0, ITXFC_OFS_INT_STS, 32'h0);
        chk(rd, 32'h0);
        eng.set_master(1'b0);
        drain();
        // preload: no lock, ready cleared until software sets it
        bus(1'b1, ITXFC_OFS_TXC_PRI, 32'h1);
        pre = 1'b1;
        sec_store[0] = 1'b0;
        chk_cnt(0);
        chk(o_addr_ack, 1'b0);
        fill(2);
        eng.fire(0);
        eng.fire(1);
        chk_cnt(2);
        bus(1'b0, ITXFC_OFS_INT_STS, 32'h0);
        chk(rd, 32'h0);
        set_sec(32'h1);
        chk(o_addr_ack, 1'b1);
        drain();
        print_verdict();
    end
endmodule // tb_top
